// File: sfwp_ctrl.sv
// serial flash operation and write-protect control
`timescale 1ns/10ps
`default_nettype none
`include "sfwp_defs.svh"

// What this block does
// - works with spi modes zero and three
// - capture on rise, drive from fall
// - protect pin low freezes protect bits
// - page write up to 256 bytes, one page
// - erase sets sector or array to ones
// - status holds cycle in progress flag
// - high voltage selects fast program mode
// - stay active until internal cycle ends
// - sleep command sleeps, wake command wakes
// - sleeping device ignores all modifying commands
// - modifying commands need whole byte count
// - modifying commands need write enable latch
// - latch cleared at powerup and completions
// - protect bits make region read only
// - protect codes map to upper sectors
// - protect pin guards protect and lock
// - full wipe only with protect bits zero
// - powerup delay blocks early changes
// - 64 sectors, 256 byte pages, no page erase
// - array access ignored during internal cycle
// - all fields shifted msb first
module sfwp_ctrl #(
    parameter int unsigned PUW_CYCLES = `SFWP_PUW_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // serial pins
    input  wire logic        sclk,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe_n,
    // protect pin levels
    input  wire logic        wp_n,
    input  wire logic        vpp_high,
    // array port
    output logic             arr_valid,
    input  wire logic        arr_ready,
    output logic [1:0]       arr_op,
    output logic [21:0]      arr_addr,
    output logic [7:0]       arr_data,
    output logic             arr_fast,
    input  wire logic        arr_done,
    // status
    output logic [7:0]       status,
    output logic             deep_sleep,
    output logic             active_mode,
    output logic             powerup_done
);

    typedef struct packed {
        logic [4:0]                  s1;
        logic [4:0]                  s2;
        logic                        sclk_d;
        logic                        seln_d;
        logic [15:0]                 puw;
        logic                        pwr_ok;
        logic [7:0]                  shreg;
        logic [2:0]                  bitcnt;
        logic [2:0]                  bytecnt;
        logic                        framing;
        logic [7:0]                  opcode;
        logic [21:0]                 addr;
        logic [7:0]                  sr_new;
        logic [8:0]                  dcnt;
        logic [7:0]                  widx;
        logic                        out_en;
        logic [7:0]                  out_sh;
        logic                        lock;
        logic [2:0]                  bp;
        logic                        write_enable_latch;
        logic                        cycle_in_progress_flag;
        logic                        sleep;
        logic                        fast;
        sfwp_pkg::sfwp_cyc_t         cyc;
        sfwp_pkg::sfwp_aop_t         aop;
        logic [8:0]                  fed;
        logic [15:0]                 tmr;
        logic [1:0]                  bcnt;
        sfwp_pkg::sfwp_entry_t [1:0] fifo;
    } sfwp_state_t;

    function automatic logic sfwp_is_protected(input logic [2:0] bp, input logic [5:0] sec);
        logic [6:0] first;
        first = 7'(`SFWP_SECTORS) - (7'h01 << (bp - 3'h1));
        if (bp == 3'h0) begin
            return 1'b0;
        end
        if (bp == 3'h7) begin
            return 1'b1;
        end
        return {1'b0, sec} >= first;
    endfunction : sfwp_is_protected

    function automatic logic [7:0] sfwp_status(input sfwp_state_t s);
        logic [7:0] r;
        r = `SFWP_SR_RST;
        r[`SFWP_SR_LOCK] = s.lock;
        r[`SFWP_SR_BP_HI:`SFWP_SR_BP_LO] = s.bp;
        r[`SFWP_SR_WEL] = s.write_enable_latch;
        r[`SFWP_SR_WIP] = s.cycle_in_progress_flag;
        return r;
    endfunction : sfwp_status

    localparam logic [7:0] SIGNATURE = 8'h5A; // arbitrary value
    sfwp_state_t st;
    sfwp_state_t next_st;
    logic [7:0]            pmem [`SFWP_PAGE_BYTES];
    logic                  mem_we;
    logic [7:0]            mem_wa;
    logic [7:0]            mem_wd;
    logic [7:0]            rd_idx;
    logic [7:0]            rd_data;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  sel_fall;
    logic                  sel_rise;
    logic                  selected;
    logic                  pop;
    logic                  push;
    sfwp_pkg::sfwp_entry_t pe;
    logic [7:0]            byte_in;
    logic                  whole;

    assign rd_idx  = st.addr[7:0] + st.fed[7:0];
    assign rd_data = pmem[rd_idx];
    always_comb begin
        next_st  = st;
        mem_we   = 1'b0;
        mem_wa   = 8'h00;
        mem_wd   = 8'h00;
        push     = 1'b0;
        pe       = '0;
        byte_in  = {st.shreg[6:0], st.s2[2]};
        next_st.s1     = {vpp_high, wp_n, mosi, sel_n, sclk};
        next_st.s2     = st.s1;
        next_st.sclk_d = st.s2[0];
        next_st.seln_d = st.s2[1];
        selected = ~st.s2[1];
        // rising edge captures in both modes, idle level irrelevant
        sck_rise = st.s2[0] & ~st.sclk_d;
        sck_fall = ~st.s2[0] & st.sclk_d;
        sel_fall = ~st.s2[1] & st.seln_d;
        sel_rise = st.s2[1] & ~st.seln_d;
        whole    = st.framing && st.bitcnt == 3'h0 && st.bytecnt != 3'h0;

        // powerup delay
        if (!st.pwr_ok) begin
            if (st.puw == 16'(PUW_CYCLES - 1)) begin
                next_st.pwr_ok = 1'b1;
            end else begin
                next_st.puw = st.puw + 16'h0001;
            end
        end

        // two-entry buffer toward the array
        pop = (st.bcnt != 2'h0) && arr_ready;
        if (pop) begin
            next_st.fifo[0] = st.fifo[1];
            next_st.bcnt    = st.bcnt - 2'h1;
        end

        // internal cycle
        case (st.cyc)
            sfwp_pkg::SFWP_CYC_ISSUE: begin
                if (next_st.bcnt != 2'h2) begin
                    push = 1'b1;
                    pe.op = st.aop;
                    if (st.aop == sfwp_pkg::SFWP_AOP_PROGRAM) begin
                        // array may only clear bits on program
                        pe.addr = {st.addr[21:8], rd_idx};
                        pe.data = rd_data;
                        next_st.fed = st.fed + 9'h001;
                        if (st.fed + 9'h001 == st.dcnt) begin
                            next_st.cyc = sfwp_pkg::SFWP_CYC_WAIT;
                        end
                    end else begin
                        pe.addr = st.addr;
                        pe.data = 8'hFF;
                        next_st.cyc = sfwp_pkg::SFWP_CYC_WAIT;
                    end
                end
            end
            sfwp_pkg::SFWP_CYC_WAIT: begin
                if (arr_done && next_st.bcnt == 2'h0) begin
                    next_st.cyc = sfwp_pkg::SFWP_CYC_IDLE;
                    next_st.cycle_in_progress_flag = 1'b0;
                    next_st.write_enable_latch = 1'b0;
                end
            end
            sfwp_pkg::SFWP_CYC_STWR: begin
                if (st.tmr == 16'(`SFWP_STWR_CYC - 1)) begin
                    next_st.cyc = sfwp_pkg::SFWP_CYC_IDLE;
                    next_st.cycle_in_progress_flag = 1'b0;
                    next_st.write_enable_latch = 1'b0;
                end else begin
                    next_st.tmr = st.tmr + 16'h0001;
                end
            end
            sfwp_pkg::SFWP_CYC_IDLE: begin
            end
            default: begin
                next_st.cyc = sfwp_pkg::SFWP_CYC_IDLE;
            end
        endcase
        if (push) begin
            next_st.fifo[next_st.bcnt[0]] = pe;
            next_st.bcnt = next_st.bcnt + 2'h1;
        end

        // serial frame
        if (sel_fall) begin
            next_st.framing = st.pwr_ok;
            next_st.bitcnt  = 3'h0;
            next_st.bytecnt = 3'h0;
            next_st.dcnt    = 9'h000;
            next_st.widx    = 8'h00;
            next_st.out_en  = 1'b0;
        end else if (selected && sck_rise && st.framing) begin
            next_st.shreg  = byte_in;
            next_st.bitcnt = st.bitcnt + 3'h1;
            if (st.bitcnt == 3'h7) begin
                if (st.bytecnt != 3'h7) begin
                    next_st.bytecnt = st.bytecnt + 3'h1;
                end
                if (st.bytecnt == 3'h0) begin
                    next_st.opcode = byte_in;
                    next_st.out_en = (byte_in == `SFWP_OP_WAKE) ||
                                     (byte_in == `SFWP_OP_STAT_RD && !st.sleep);
                    if (byte_in == `SFWP_OP_WAKE) begin
                        next_st.sleep = 1'b0;
                    end
                end else if (st.bytecnt < 3'h4 && st.cyc == sfwp_pkg::SFWP_CYC_IDLE) begin
                    next_st.addr = {st.addr[13:0], byte_in};
                end
                if (st.bytecnt == 3'h1) begin
                    next_st.sr_new = byte_in;
                end
                if (st.bytecnt >= 3'h4 && st.opcode == `SFWP_OP_PAGE_WR &&
                    !st.sleep && st.cyc == sfwp_pkg::SFWP_CYC_IDLE) begin
                    mem_we       = 1'b1;
                    mem_wa       = st.addr[7:0] + st.widx;
                    mem_wd       = byte_in;
                    next_st.widx = st.widx + 8'h01;
                    if (st.dcnt != 9'(`SFWP_PAGE_BYTES)) begin
                        next_st.dcnt = st.dcnt + 9'h001;
                    end
                end
            end
        end

        // output shifts on falling edges, reloads at byte boundary
        if (selected && sck_fall && st.out_en) begin
            if (st.bitcnt == 3'h0) begin
                next_st.out_sh = (st.opcode == `SFWP_OP_STAT_RD) ? sfwp_status(st) : SIGNATURE;
            end else begin
                next_st.out_sh = {st.out_sh[6:0], 1'b0};
            end
        end

        // execute at deselect; busy and sleeping states refuse
        if (sel_rise) begin
            next_st.framing = 1'b0;
            next_st.out_en  = 1'b0;
            if (whole && st.pwr_ok && !st.sleep &&
                st.cyc == sfwp_pkg::SFWP_CYC_IDLE) begin
                case (st.opcode)
                    `SFWP_OP_LATCH_SET: begin
                        next_st.write_enable_latch = 1'b1;
                    end
                    `SFWP_OP_LATCH_CLR: begin
                        next_st.write_enable_latch = 1'b0;
                    end
                    `SFWP_OP_SLEEP: begin
                        next_st.sleep = 1'b1;
                    end
                    `SFWP_OP_STAT_WR: begin
                        if (st.bytecnt >= 3'h2 && st.write_enable_latch) begin
                            if (st.s2[3]) begin
                                next_st.lock = st.sr_new[`SFWP_SR_LOCK];
                                next_st.bp   = st.sr_new[`SFWP_SR_BP_HI:`SFWP_SR_BP_LO];
                            end
                            next_st.cyc = sfwp_pkg::SFWP_CYC_STWR;
                            next_st.cycle_in_progress_flag = 1'b1;
                            next_st.tmr = 16'h0000;
                        end
                    end
                    `SFWP_OP_PAGE_WR: begin
                        if (st.bytecnt >= 3'h5 && st.write_enable_latch &&
                            !sfwp_is_protected(st.bp, st.addr[21:16])) begin
                            next_st.cyc  = sfwp_pkg::SFWP_CYC_ISSUE;
                            next_st.aop  = sfwp_pkg::SFWP_AOP_PROGRAM;
                            next_st.fed  = 9'h000;
                            next_st.cycle_in_progress_flag  = 1'b1;
                            next_st.fast = st.s2[4];
                        end
                    end
                    `SFWP_OP_SECT_WIPE: begin
                        if (st.bytecnt == 3'h4 && st.write_enable_latch &&
                            !sfwp_is_protected(st.bp, st.addr[21:16])) begin
                            next_st.cyc  = sfwp_pkg::SFWP_CYC_ISSUE;
                            next_st.aop  = sfwp_pkg::SFWP_AOP_SECTOR;
                            next_st.addr = {st.addr[21:16], 16'h0000};
                            next_st.cycle_in_progress_flag  = 1'b1;
                            next_st.fast = st.s2[4];
                        end
                    end
                    `SFWP_OP_FULL_WIPE: begin
                        if (st.bytecnt == 3'h1 && st.write_enable_latch && st.bp == 3'h0) begin
                            next_st.cyc  = sfwp_pkg::SFWP_CYC_ISSUE;
                            next_st.aop  = sfwp_pkg::SFWP_AOP_FULL;
                            next_st.addr = 22'h00_0000;
                            next_st.cycle_in_progress_flag  = 1'b1;
                            next_st.fast = st.s2[4];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st        <= '0;
            st.s1     <= `SFWP_SYNC_RST;
            st.s2     <= `SFWP_SYNC_RST;
            st.seln_d <= 1'b1;
            st.cyc    <= sfwp_pkg::SFWP_CYC_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // staged page bytes
    always_ff @(posedge clk) begin
        if (mem_we) begin
            pmem[mem_wa] <= mem_wd;
        end
    end

    // outputs
    assign miso         = st.out_sh[7];
    assign miso_oe_n    = ~(selected & st.out_en);
    assign arr_valid    = st.bcnt != 2'h0;
    assign arr_op       = st.fifo[0].op;
    assign arr_addr     = st.fifo[0].addr;
    assign arr_data     = st.fifo[0].data;
    assign arr_fast     = st.fast;
    assign status       = sfwp_status(st);
    assign deep_sleep   = st.sleep;
    assign active_mode  = selected | st.cycle_in_progress_flag;
    assign powerup_done = st.pwr_ok;
endmodule : sfwp_ctrl
`default_nettype wire

// File: sfwp_defs.svh
// constants of the serial flash write-protect control block
`ifndef SFWP_DEFS_SVH
`define SFWP_DEFS_SVH

// clock and timing
`define SFWP_CLK_NS        10
`define SFWP_PUW_NS        10000
`define SFWP_PUW_CYC       ((`SFWP_PUW_NS + `SFWP_CLK_NS - 1) / `SFWP_CLK_NS)
`define SFWP_STWR_NS       5000
`define SFWP_STWR_CYC      ((`SFWP_STWR_NS + `SFWP_CLK_NS - 1) / `SFWP_CLK_NS)

// command codes
`define SFWP_OP_LATCH_SET  8'h06
`define SFWP_OP_LATCH_CLR  8'h04
`define SFWP_OP_STAT_RD    8'h05
`define SFWP_OP_STAT_WR    8'h01
`define SFWP_OP_PAGE_WR    8'h02
`define SFWP_OP_SECT_WIPE  8'hD8
`define SFWP_OP_FULL_WIPE  8'hC7
`define SFWP_OP_SLEEP      8'hB9
`define SFWP_OP_WAKE       8'hAB

// status byte field positions
`define SFWP_SR_LOCK       7
`define SFWP_SR_BP_HI      4
`define SFWP_SR_BP_LO      2
`define SFWP_SR_WEL        1
`define SFWP_SR_WIP        0

// array geometry
`define SFWP_SECTORS       64
`define SFWP_PAGE_BYTES    256

// reset values
`define SFWP_SYNC_RST      5'h02
`define SFWP_SR_RST        8'h00

`endif

// File: sfwp_pkg.sv
// types of the serial flash write-protect control block
package sfwp_pkg;

    typedef enum logic [3:0] {
        SFWP_CYC_IDLE  = 4'b0001,
        SFWP_CYC_ISSUE = 4'b0010,
        SFWP_CYC_WAIT  = 4'b0100,
        SFWP_CYC_STWR  = 4'b1000
    } sfwp_cyc_t;

    typedef enum logic [1:0] {
        SFWP_AOP_PROGRAM = 2'b00,
        SFWP_AOP_SECTOR  = 2'b01,
        SFWP_AOP_FULL    = 2'b10
    } sfwp_aop_t;

    typedef struct packed {
        sfwp_aop_t   op;
        logic [21:0] addr;
        logic [7:0]  data;
    } sfwp_entry_t;

endpackage : sfwp_pkg

// File: sfwp_ctrl_properties.sv
// assertion checker for the flash operation and protect control
`timescale 1ns/10ps
`default_nettype none
module sfwp_ctrl_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // pins
    input wire logic        sel_n,
    input wire logic        miso_oe_n,
    input wire logic        wp_n,
    // array port
    input wire logic        arr_valid,
    input wire logic        arr_ready,
    input wire logic [1:0]  arr_op,
    input wire logic [21:0] arr_addr,
    input wire logic [7:0]  arr_data,
    // status
    input wire logic [7:0]  status,
    input wire logic        deep_sleep,
    input wire logic        active_mode,
    input wire logic        powerup_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_stall;
        arr_valid && !arr_ready;
    endsequence
    sequence s_wp_low;
        !wp_n [*4];
    endsequence

    chk_arr_hold: assert property (s_stall |=> arr_valid && $stable({arr_op, arr_addr, arr_data}))
        else $error("array request changed while stalled");
    chk_erase_ones: assert property (arr_valid && arr_op != 2'h0 |-> arr_data == 8'hFF)
        else $error("erase entry without all ones");
    chk_full_clear: assert property (arr_valid && arr_op == 2'h2 |-> status[4:2] == 3'h0)
        else $error("full wipe with protect bits set");
    chk_busy_flag: assert property (arr_valid |-> status[0])
        else $error("array request without busy flag");
    chk_sleep_quiet: assert property (deep_sleep |-> !arr_valid)
        else $error("array request while sleeping");
    chk_stay_active: assert property (status[0] |-> active_mode)
        else $error("standby during internal cycle");
    chk_standby_idle: assert property (sel_n [*4] ##0 !status[0] |-> !active_mode)
        else $error("active while deselected and idle");
    chk_latch_drop: assert property ($fell(status[0]) |-> !status[1])
        else $error("latch still set after cycle end");
    chk_bp_freeze: assert property (s_wp_low |=> $stable(status[7:2]))
        else $error("protect bits changed with pin low");
    chk_powerup_wait: assert property (!powerup_done |-> !status[1] && !arr_valid)
        else $error("change before powerup delay");
    chk_oe_off: assert property (sel_n [*4] |-> miso_oe_n)
        else $error("output driven while deselected");
endmodule : sfwp_ctrl_properties

bind sfwp_ctrl sfwp_ctrl_properties u_sfwp_ctrl_properties (
    .clk, .rst_n, .sel_n, .miso_oe_n, .wp_n, .arr_valid, .arr_ready, .arr_op,
    .arr_addr, .arr_data, .status, .deep_sleep, .active_mode, .powerup_done
);
`default_nettype wire

// File: sfwp_array_model.sv
// array side model: stalls requests, records entries, reports completion
`timescale 1ns/10ps
`default_nettype none
module sfwp_array_model #(
    parameter int DONE_DLY = 600
) (
    // clock and reset
    input wire logic         clk,
    input wire logic         rst_n,
    // request side
    input wire logic         slow,
    input wire logic         arr_valid,
    output logic             arr_ready,
    input wire logic [1:0]   arr_op,
    input wire logic [21:0]  arr_addr,
    input wire logic [7:0]   arr_data,
    input wire logic         arr_fast,
    output logic             arr_done,
    // record of taken entries
    output logic [15:0]      seen_cnt,
    output logic [1:0]       seen_op,
    output logic [21:0]      seen_addr,
    output logic [7:0]       seen_data,
    output logic             seen_fast
);
    logic [9:0] idle;
    logic [1:0] ph;
    // stall two cycles of four when slow
    assign arr_ready = !slow || ph[1];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 2'h0;
            idle <= 10'h0;
            arr_done <= 1'b0;
            {seen_cnt, seen_op, seen_addr, seen_data, seen_fast} <= '0;
        end else begin
            ph <= ph + 2'h1;
            arr_done <= 1'b0;
            if (arr_valid && arr_ready) begin
                seen_cnt <= seen_cnt + 16'h1;
                {seen_op, seen_addr, seen_data, seen_fast} <= {arr_op, arr_addr, arr_data, arr_fast};
                idle <= 10'h1;
            end else if (idle == 10'(DONE_DLY)) begin
                arr_done <= 1'b1;
                idle <= 10'h0;
            end else if (idle != 10'h0 && !arr_valid) begin
                idle <= idle + 10'h1;
            end
        end
    end
endmodule : sfwp_array_model
`default_nettype wire

// File: sfwp_ctrl_tb.sv
// testbench for the flash operation and protect control
`timescale 1ns/10ps
`default_nettype none
`include "sfwp_defs.svh"
module sfwp_ctrl_tb;
    logic        clk, rst_n, sclk, sel_n, mosi, wp_n, vpp_high, slow, mode3;
    logic        miso, miso_oe_n, arr_valid, arr_ready, arr_fast, arr_done;
    logic [1:0]  arr_op, seen_op;
    logic [21:0] arr_addr, seen_addr;
    logic [7:0]  arr_data, seen_data, status, s;
    logic        deep_sleep, active_mode, powerup_done, seen_fast;
    logic [15:0] seen_cnt;
    int          mismatches, checked, n, k, lo, cnt;

    sfwp_ctrl #(.PUW_CYCLES(8)) u_sfwp_ctrl (.clk, .rst_n, .sclk, .sel_n, .mosi, .miso,
        .miso_oe_n, .wp_n, .vpp_high, .arr_valid, .arr_ready, .arr_op, .arr_addr, .arr_data,
        .arr_fast, .arr_done, .status, .deep_sleep, .active_mode, .powerup_done);
    sfwp_array_model u_sfwp_array_model (.clk, .rst_n, .slow, .arr_valid, .arr_ready,
        .arr_op, .arr_addr, .arr_data, .arr_fast, .arr_done, .seen_cnt, .seen_op,
        .seen_addr, .seen_data, .seen_fast);

    always #5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // one frame, tx left aligned, msb first, sampled at each rise
    task automatic spi(input logic [63:0] tx, input int nb, output logic [7:0] rx);
        sel_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < nb; i++) begin
            sclk = 1'b0;
            mosi = tx[63 - i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            rx = {rx[6:0], miso};
            repeat (4) @(negedge clk);
        end
        sclk = mode3;
        repeat (4) @(negedge clk);
        sel_n = 1'b1;
        mosi = ~mosi;
        repeat (8) @(negedge clk);
    endtask : spi

    task automatic cmd(input logic [63:0] tx, input int nb);
        logic [7:0] r;
        spi(tx, nb, r);
    endtask : cmd

    task automatic latch;
        cmd({`SFWP_OP_LATCH_SET, 56'h0}, 8);
    endtask : latch

    task automatic rdsr(output logic [7:0] v);
        spi({`SFWP_OP_STAT_RD, 56'h0}, 16, v);
    endtask : rdsr

    task automatic idle_wait;
        logic [7:0] v;
        v = 8'h01;
        for (int j = 0; j < 60 && v[0] !== 1'b0; j++) rdsr(v);
        check(v[0], 1'b0);
    endtask : idle_wait

    task automatic wipe(input logic [21:0] a);
        latch();
        cmd({`SFWP_OP_SECT_WIPE, 2'h0, a, 32'h0}, 32);
        idle_wait();
    endtask : wipe

    task automatic status_write_cmd(input logic [7:0] v);
        latch();
        cmd({`SFWP_OP_STAT_WR, v, 48'h0}, 16);
        idle_wait();
    endtask : status_write_cmd

    initial begin
        #1_000_000;
        mismatches++;
        summarize();
    end

    initial begin
        {clk, rst_n, sclk, mosi, vpp_high, mode3} = '0;
        {sel_n, wp_n, slow} = 3'h7;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        for (n = 0; n < 50 && powerup_done !== 1'b1; n++) @(negedge clk);
        check(powerup_done, 1'b1);
        rdsr(s);
        check(s, 8'h00);
        cmd({`SFWP_OP_LATCH_SET, 56'h0}, 9);
        rdsr(s);
        check(s[1], 1'b0);
        latch();
        rdsr(s);
        check(s[1], 1'b1);
        cmd({`SFWP_OP_LATCH_CLR, 56'h0}, 8);
        rdsr(s);
        check(s[1], 1'b0);
        latch();
        // page write in mode three, wrapping inside the page
        mode3 = 1'b1;
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        cmd({`SFWP_OP_PAGE_WR, 24'h00_12FF, 8'hA5, 8'h3C, 16'h0}, 48);
        idle_wait();
        cnt = 2;
        check(seen_cnt, cnt);
        check(seen_addr, 22'h00_1200);
        check({seen_op, seen_data, seen_fast}, {2'h0, 8'h3C, 1'b0});
        rdsr(s);
        check(s, 8'h00);
        mode3 = 1'b0;
        sclk = 1'b0;
        // no latch, no write
        cmd({`SFWP_OP_PAGE_WR, 24'h00_0000, 8'h00, 24'h0}, 40);
        idle_wait();
        check(seen_cnt, cnt);
        // erase with high voltage
        vpp_high = 1'b1;
        wipe(22'h05_0000);
        cnt++;
        check(seen_cnt, cnt);
        check({seen_op, seen_addr, seen_data}, {2'h1, 22'h05_0000, 8'hFF});
        check(seen_fast, 1'b1);
        vpp_high = 1'b0;
        // every protect code, bounds and full wipe
        for (k = 7; k >= 0; k--) begin
            status_write_cmd({3'h0, k[2:0], 2'h0});
            rdsr(s);
            check(s[4:2], k[2:0]);
            lo = (k == 0) ? 64 : (k == 7) ? 0 : 64 - (1 << (k - 1));
            if (lo < 64) begin
                wipe({lo[5:0], 16'h0});
                check(seen_cnt, cnt);
            end
            if (lo > 0) begin
                wipe({6'(lo - 1), 16'h0});
                cnt++;
                check(seen_addr, {6'(lo - 1), 16'h0});
            end
            latch();
            cmd({`SFWP_OP_FULL_WIPE, 56'h0}, 8);
            idle_wait();
            if (k == 0) cnt++;
            check(seen_cnt, cnt);
        end
        check(seen_op, 2'h2);
        // pin low guards protect and lock bits
        wp_n = 1'b0;
        repeat (8) @(negedge clk);
        status_write_cmd(8'h8C);
        rdsr(s);
        check(s & 8'h9C, 8'h00);
        wp_n = 1'b1;
        // sleeping device ignores writes
        cmd({`SFWP_OP_SLEEP, 56'h0}, 8);
        check(deep_sleep, 1'b1);
        latch();
        cmd({`SFWP_OP_SECT_WIPE, 24'h01_0000, 32'h0}, 32);
        repeat (50) @(negedge clk);
        check(seen_cnt, cnt);
        cmd({`SFWP_OP_WAKE, 56'h0}, 8);
        check(deep_sleep, 1'b0);
        // second erase during running cycle is ignored
        latch();
        cmd({`SFWP_OP_SECT_WIPE, 24'h01_0000, 32'h0}, 32);
        check(active_mode, 1'b1);
        latch();
        cmd({`SFWP_OP_SECT_WIPE, 24'h02_0000, 32'h0}, 32);
        idle_wait();
        cnt++;
        check(seen_cnt, cnt);
        check(seen_addr, 22'h01_0000);
        check(active_mode, 1'b0);
        summarize();
    end
endmodule : sfwp_ctrl_tb
`default_nettype wire
